/* File: rtl/charger_regs_pkg.sv */
// constants shared by the charger register bank and its two-wire target
// assumes a single 40 MHz clock and a synchronous active-low reset
`default_nettype none

package charger_regs_pkg;

    // target address on the two-wire bus
    localparam logic [6:0] TARGET_ADDRESS = 7'h6a;

    // register offsets
    localparam logic [7:0] OFFS_INPUT_LIMIT = 8'h00;
    localparam logic [7:0] OFFS_CONTROL_ZERO = 8'h01;
    localparam logic [7:0] OFFS_CHARGE_CURRENT = 8'h02;
    localparam logic [7:0] OFFS_PRECHARGE_TERM = 8'h03;
    localparam logic [7:0] OFFS_BATTERY_VOLTAGE = 8'h04;
    localparam logic [7:0] OFFS_CONTROL_ONE = 8'h05;
    localparam logic [7:0] OFFS_CONTROL_TWO = 8'h06;
    localparam logic [7:0] OFFS_CONTROL_THREE = 8'h07;
    localparam logic [7:0] OFFS_STATUS_ZERO = 8'h08;
    localparam logic [7:0] OFFS_STATUS_ONE = 8'h09;
    localparam logic [7:0] OFFS_STATUS_TWO = 8'h0a;
    localparam logic [7:0] OFFS_PART_INFO = 8'h0b;
    localparam logic [7:0] OFFS_CONTROL_FOUR = 8'h0c;
    localparam logic [7:0] LAST_OFFSET = 8'h0c;
    localparam logic [7:0] POINTER_MAX = 8'hff;
    localparam int REG_COUNT = 13;

    // value returned for any offset above the last register
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'hff;

    // reset values, indexed by offset; read-only slots are unused
    localparam logic [7:0] RST_INPUT_LIMIT = 8'h17;
    localparam logic [7:0] RW_RESET [0:REG_COUNT-1] = '{
        8'h17, 8'h1a, 8'h91, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
    };

    // input current limit register fields
    localparam int HIZ_BIT = 7;
    localparam int THERM_BYPASS_BIT = 6;
    localparam int SENSE_DISABLE_BIT = 5;
    localparam int CODE_MSB = 4;

    // limit codes loaded when source detection completes
    localparam logic [4:0] LIMIT_CODE_PSEL_HIGH = 5'h04;
    localparam logic [4:0] LIMIT_CODE_PSEL_LOW = 5'h17;

    // limit current = code * step + offset, in mA
    localparam logic [11:0] LIMIT_STEP_MA = 12'h064;
    localparam logic [11:0] LIMIT_OFFSET_MA = 12'h064;

    localparam logic [2:0] THERM_FAULT_NORMAL = 3'h0;

    // bus engine states, gray coded along the usual path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_OFFSET = 4'h2,
        ST_OFFSET_ACK = 4'h6,
        ST_WDATA = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RDATA = 4'h4,
        ST_RACK = 4'hc
    } bus_state_t;

endpackage

`default_nettype wire

/* File: rtl/i2c_line_sampler.sv */
// two-flop synchronisers on both bus lines, edge and start/stop detection
// assumes scl and sda arrive asynchronously from the bus pins
`default_nettype none

module i2c_line_sampler (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus pins
    input wire logic scl_pin,
    input wire logic sda_pin,
    // sampled lines and events
    output logic sda_level,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_seen,
    output logic stop_seen
);

    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic sda_prev;

    // idle bus is high on both lines
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= scl_pin;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_pin;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end

    assign sda_level = sda_sync;
    assign scl_rise = scl_sync & ~scl_prev;
    assign scl_fall = ~scl_sync & scl_prev;
    // sda moving while scl stays high marks start or stop
    assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
    assign stop_seen = scl_sync & scl_prev & ~sda_prev & sda_sync;

endmodule // i2c_line_sampler

`default_nettype wire

/* File: rtl/charger_register_bank.sv */
// charger register bank behind a two-wire target port
// assumes status bytes and charger events come from logic on the same clock
`default_nettype none

module charger_register_bank (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // two-wire bus; sda is open drain, driven low while sda_oe_n is low
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // charger events and pins
    input wire logic power_select_pin,
    input wire logic detection_done,
    input wire logic reg_reset,
    input wire logic watchdog_expired,
    input wire logic remote_sense_fault_flag,
    input wire logic thermistor_input_ok,
    input wire logic [2:0] thermistor_fault_raw,
    // read-only register contents
    input wire logic [7:0] status_zero_reg,
    input wire logic [7:0] status_one_reg,
    input wire logic [7:0] status_two_reg,
    input wire logic [7:0] part_info_reg,
    // input limit controls
    output logic high_impedance_enable,
    output logic thermistor_bypass,
    output logic thermistor_good,
    output logic [2:0] thermistor_fault_field,
    output logic remote_sense_disable,
    output logic use_remote_sense,
    output logic [4:0] input_current_limit_code,
    output logic [11:0] input_current_limit_ma,
    // other read/write registers
    output logic [7:0] charger_control_zero,
    output logic [7:0] charge_current_limit,
    output logic [7:0] precharge_termination_current,
    output logic [7:0] battery_voltage_limit,
    output logic [7:0] charger_control_one,
    output logic [7:0] charger_control_two,
    output logic [7:0] charger_control_three,
    output logic [7:0] control_four_reg
);

    import charger_regs_pkg::*;

    function automatic logic is_writable(input logic [7:0] idx);
        is_writable = (idx <= LAST_OFFSET) && ((idx < OFFS_STATUS_ZERO)
            || (idx > OFFS_PART_INFO));
    endfunction

    logic sda_level;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    i2c_line_sampler line_sampler (
        .clock(clock),
        .rst_n(rst_n),
        .scl_pin(scl_in),
        .sda_pin(sda_in),
        .sda_level(sda_level),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_seen(start_seen),
        .stop_seen(stop_seen)
    );

    bus_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shifter;
    logic byte_got;
    logic read_dir;
    logic host_nack;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic [7:0] next_tx;
    logic wr_pulse;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic [7:0] input_limit_reg;
    logic [7:0] rw_file [0:REG_COUNT-1];
    logic psel_meta;
    logic psel_sync;

    // power-select is a pin: two flops before use
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            psel_meta <= 1'b0;
            psel_sync <= 1'b0;
        end else begin
            psel_meta <= power_select_pin;
            psel_sync <= psel_meta;
        end
    end

    // read data selection; the pointer stops at its top value
    always_comb begin
        next_ptr = (ptr == POINTER_MAX) ? ptr : ptr + 8'h01;
        case (ptr)
            OFFS_INPUT_LIMIT: next_tx = input_limit_reg;
            OFFS_STATUS_ZERO: next_tx = status_zero_reg;
            OFFS_STATUS_ONE: next_tx = status_one_reg;
            OFFS_STATUS_TWO: next_tx = status_two_reg;
            OFFS_PART_INFO: next_tx = part_info_reg;
            default: begin
                if (ptr <= LAST_OFFSET) begin
                    next_tx = rw_file[ptr[3:0]];
                end else begin
                    next_tx = UNMAPPED_READ_VALUE;
                end
            end
        endcase
    end

    // sda is only ever pulled low, never driven high
    always_ff @(posedge clock) begin
        sda_out <= 1'b0;
    end

    // bus engine
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            shifter <= 8'h00;
            byte_got <= 1'b0;
            read_dir <= 1'b0;
            host_nack <= 1'b0;
            ptr <= 8'h00;
            sda_oe_n <= 1'b1;
            wr_pulse <= 1'b0;
            wr_idx <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_pulse <= 1'b0;
            if (stop_seen) begin
                state <= ST_IDLE;
                byte_got <= 1'b0;
                sda_oe_n <= 1'b1;
            end else if (start_seen) begin
                // a repeated start keeps the pointer for the read phase
                state <= ST_ADDR;
                bit_cnt <= 3'h0;
                byte_got <= 1'b0;
                sda_oe_n <= 1'b1;
            end else begin
                case (state)
                    ST_ADDR, ST_OFFSET, ST_WDATA: begin
                        if (scl_rise) begin
                            shifter <= {shifter[6:0], sda_level};
                            bit_cnt <= bit_cnt + 3'h1;
                            byte_got <= (bit_cnt == 3'h7);
                        end else if (scl_fall && byte_got) begin
                            byte_got <= 1'b0;
                            bit_cnt <= 3'h0;
                            if (state == ST_ADDR) begin
                                if (shifter[7:1] == TARGET_ADDRESS) begin
                                    sda_oe_n <= 1'b0;
                                    read_dir <= shifter[0];
                                    state <= ST_ADDR_ACK;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else if (state == ST_OFFSET) begin
                                if (shifter <= LAST_OFFSET) begin
                                    sda_oe_n <= 1'b0;
                                    ptr <= shifter;
                                    state <= ST_OFFSET_ACK;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else begin
                                wr_pulse <= 1'b1;
                                wr_idx <= ptr;
                                wr_data <= shifter;
                                ptr <= next_ptr;
                                sda_oe_n <= 1'b0;
                                state <= ST_WDATA_ACK;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (read_dir) begin
                                shifter <= next_tx;
                                sda_oe_n <= next_tx[7];
                                ptr <= next_ptr;
                                state <= ST_RDATA;
                            end else begin
                                sda_oe_n <= 1'b1;
                                state <= ST_OFFSET;
                            end
                        end
                    end
                    ST_OFFSET_ACK, ST_WDATA_ACK: begin
                        if (scl_fall) begin
                            sda_oe_n <= 1'b1;
                            state <= ST_WDATA;
                        end
                    end
                    ST_RDATA: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 3'h1;
                            byte_got <= (bit_cnt == 3'h7);
                        end else if (scl_fall) begin
                            if (byte_got) begin
                                byte_got <= 1'b0;
                                bit_cnt <= 3'h0;
                                sda_oe_n <= 1'b1;
                                state <= ST_RACK;
                            end else begin
                                sda_oe_n <= shifter[6];
                                shifter <= {shifter[6:0], 1'b0};
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            host_nack <= sda_level;
                        end else if (scl_fall) begin
                            if (host_nack) begin
                                state <= ST_IDLE;
                            end else begin
                                shifter <= next_tx;
                                sda_oe_n <= next_tx[7];
                                ptr <= next_ptr;
                                state <= ST_RDATA;
                            end
                        end
                    end
                    ST_IDLE: begin
                        sda_oe_n <= 1'b1;
                    end
                    default: begin
                        state <= ST_IDLE;
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    // input limit register; later assignments take priority
    always_ff @(posedge clock) begin
        if (!rst_n || reg_reset) begin
            input_limit_reg <= RST_INPUT_LIMIT;
        end else begin
            if (wr_pulse && (wr_idx == OFFS_INPUT_LIMIT)) begin
                input_limit_reg <= wr_data;
            end
            if (watchdog_expired) begin
                input_limit_reg[HIZ_BIT] <= 1'b0;
            end
            if (detection_done) begin
                input_limit_reg[CODE_MSB:0] <= psel_sync ? LIMIT_CODE_PSEL_HIGH
                    : LIMIT_CODE_PSEL_LOW;
            end
        end
    end

    // remaining registers; read-only slots hold no storage
    generate
        for (genvar i = 1; i < REG_COUNT; i++) begin : g_regs
            if (is_writable(8'(i))) begin : g_rw
                always_ff @(posedge clock) begin
                    if (!rst_n || reg_reset) begin
                        rw_file[i] <= RW_RESET[i];
                    end else if (wr_pulse && (wr_idx == 8'(i))) begin
                        rw_file[i] <= wr_data;
                    end
                end
            end else begin : g_ro
                assign rw_file[i] = 8'h00;
            end
        end
    endgenerate
    assign rw_file[0] = 8'h00;

    assign charger_control_zero = rw_file[OFFS_CONTROL_ZERO[3:0]];
    assign charge_current_limit = rw_file[OFFS_CHARGE_CURRENT[3:0]];
    assign precharge_termination_current = rw_file[OFFS_PRECHARGE_TERM[3:0]];
    assign battery_voltage_limit = rw_file[OFFS_BATTERY_VOLTAGE[3:0]];
    assign charger_control_one = rw_file[OFFS_CONTROL_ONE[3:0]];
    assign charger_control_two = rw_file[OFFS_CONTROL_TWO[3:0]];
    assign charger_control_three = rw_file[OFFS_CONTROL_THREE[3:0]];
    assign control_four_reg = rw_file[OFFS_CONTROL_FOUR[3:0]];

    // controls derived from the input limit register, one cycle behind it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            high_impedance_enable <= 1'b0;
            thermistor_bypass <= 1'b0;
            thermistor_good <= 1'b0;
            thermistor_fault_field <= THERM_FAULT_NORMAL;
            remote_sense_disable <= 1'b0;
            use_remote_sense <= 1'b0;
            input_current_limit_code <= RST_INPUT_LIMIT[CODE_MSB:0];
            input_current_limit_ma <= 12'(RST_INPUT_LIMIT[CODE_MSB:0]) * LIMIT_STEP_MA
                + LIMIT_OFFSET_MA;
        end else begin
            high_impedance_enable <= input_limit_reg[HIZ_BIT];
            thermistor_bypass <= input_limit_reg[THERM_BYPASS_BIT];
            thermistor_good <= input_limit_reg[THERM_BYPASS_BIT]
                | thermistor_input_ok;
            thermistor_fault_field <= input_limit_reg[THERM_BYPASS_BIT]
                ? THERM_FAULT_NORMAL : thermistor_fault_raw;
            remote_sense_disable <= input_limit_reg[SENSE_DISABLE_BIT];
            use_remote_sense <= ~input_limit_reg[SENSE_DISABLE_BIT]
                & ~remote_sense_fault_flag;
            input_current_limit_code <= input_limit_reg[CODE_MSB:0];
            input_current_limit_ma <= {7'h00, input_limit_reg[CODE_MSB:0]} * LIMIT_STEP_MA
                + LIMIT_OFFSET_MA;
        end
    end

endmodule // charger_register_bank

`default_nettype wire

/* File: tb/charger_register_bank_asserts.sv */
// port checks for the charger register bank
// assumes one clock and a synchronous active-low reset; bound below
`default_nettype none

module charger_register_bank_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus and events
    input wire logic scl_in,
    input wire logic sda_oe_n,
    input wire logic power_select_pin,
    input wire logic detection_done,
    input wire logic reg_reset,
    input wire logic watchdog_expired,
    input wire logic remote_sense_fault_flag,
    // input limit controls
    input wire logic high_impedance_enable,
    input wire logic thermistor_bypass,
    input wire logic thermistor_good,
    input wire logic [2:0] thermistor_fault_field,
    input wire logic remote_sense_disable,
    input wire logic use_remote_sense,
    input wire logic [4:0] input_current_limit_code,
    input wire logic [11:0] input_current_limit_ma
);
    import charger_regs_pkg::*;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // register-reset state of the limit register as seen at the outputs
    sequence s_defaults;
        input_current_limit_code == RST_INPUT_LIMIT[4:0] && !high_impedance_enable &&
            !thermistor_bypass && !remote_sense_disable;
    endsequence

    a_limit_math: assert property ($past(rst_n) && $past(rst_n, 2) |->
        input_current_limit_ma == 12'(input_current_limit_code) * LIMIT_STEP_MA + LIMIT_OFFSET_MA)
        else $error("limit current does not match code");
    a_release_default: assert property ($rose(rst_n) |-> ##3 s_defaults ##0
        input_current_limit_ma == 12'h960) else $error("wrong limit after reset");
    a_regreset_defaults: assert property (reg_reset |-> ##2 s_defaults)
        else $error("register reset left limit fields set");
    a_wdog_hiz: assert property (watchdog_expired |-> ##2 !high_impedance_enable)
        else $error("watchdog expiry kept high impedance mode");
    a_detect_load: assert property (detection_done && !reg_reset |-> ##2
        input_current_limit_code == ($past(power_select_pin, 4) ? 5'h04 : 5'h17))
        else $error("detection loaded wrong limit code");
    a_bypass_fault: assert property (thermistor_bypass |->
        thermistor_fault_field == THERM_FAULT_NORMAL && thermistor_good)
        else $error("thermistor bypass not honoured");
    a_sense_select: assert property ($past(rst_n) |-> use_remote_sense ==
        (!remote_sense_disable && !$past(remote_sense_fault_flag)))
        else $error("wrong battery sense selection");
    a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data line changed while bus clock high");
endmodule // charger_register_bank_asserts

bind charger_register_bank charger_register_bank_asserts u_charger_register_bank_asserts (
    .clock, .rst_n, .scl_in, .sda_oe_n, .power_select_pin, .detection_done, .reg_reset,
    .watchdog_expired, .remote_sense_fault_flag, .high_impedance_enable, .thermistor_bypass,
    .thermistor_good, .thermistor_fault_field, .remote_sense_disable, .use_remote_sense,
    .input_current_limit_code, .input_current_limit_ma);

`default_nettype wire

/* File: tb/i2c_host_model.sv */
// behavioural two-wire bus controller standing in for the host
// assumes the bench resolves the open-drain data wire with a pull-up
`default_nettype none

module i2c_host_model (
    // clock
    input wire logic clock,
    // resolved data wire and host drives
    input wire logic sda_wire,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 100ps;

    // bus clock phase length in system clocks; raise it for a slow host
    int phase = 6;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic half();
        repeat (phase) @(posedge clock);
        #2;
    endtask

    // also serves as repeated start; data is released with the clock low, then pulled low with the clock high
    task automatic start_cond();
        half();
        sda_pull = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_pull = 1'b1;
        half();
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        half();
        sda_pull = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_pull = 1'b0;
        half();
    endtask

    task automatic xfer_bit(input logic b, output logic r);
        half();
        sda_pull = ~b;
        half();
        scl = 1'b1;
        half();
        r = sda_wire;
        scl = 1'b0;
    endtask

    // msb first, ninth clock carries the acknowledge
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, d[i]);
        end
        xfer_bit(nack, r);
    endtask
endmodule // i2c_host_model

`default_nettype wire

/* File: tb/tb_charger_register_bank.sv */
// self-checking bench for the charger register bank
// assumes the host model and the bound checker are compiled first
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end

module tb_charger_register_bank;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda_pull, sda_wire, sda_out, sda_oe_n;
    logic power_select_pin = 1'b0, detection_done = 1'b0, reg_reset = 1'b0;
    logic watchdog_expired = 1'b0, remote_sense_fault_flag = 1'b0, thermistor_input_ok = 1'b0;
    logic [2:0] thermistor_fault_raw = 3'h0, thermistor_fault_field;
    logic [7:0] status_zero_reg = 8'h00, status_one_reg = 8'h00;
    logic [7:0] status_two_reg = 8'h00, part_info_reg = 8'h00;
    logic high_impedance_enable, thermistor_bypass, thermistor_good;
    logic remote_sense_disable, use_remote_sense;
    logic [4:0] input_current_limit_code;
    logic [11:0] input_current_limit_ma;
    logic [7:0] d0, rw_out [0:7];
    logic [7:0] model [0:12];
    logic [7:0] q [$];
    int err_total = 0;
    int num_checks = 0;

    always #12.5 clock = ~clock;
    // open-drain wire with pull-up
    assign sda_wire = ~(sda_pull | (~sda_oe_n & ~sda_out));

    i2c_host_model u_i2c_host_model (.clock, .sda_wire, .scl, .sda_pull);

    charger_register_bank u_charger_register_bank (.clock, .rst_n, .scl_in(scl),
        .sda_in(sda_wire), .sda_out, .sda_oe_n, .power_select_pin, .detection_done, .reg_reset,
        .watchdog_expired, .remote_sense_fault_flag, .thermistor_input_ok,
        .thermistor_fault_raw, .status_zero_reg, .status_one_reg, .status_two_reg,
        .part_info_reg, .high_impedance_enable, .thermistor_bypass, .thermistor_good,
        .thermistor_fault_field, .remote_sense_disable, .use_remote_sense,
        .input_current_limit_code, .input_current_limit_ma, .charger_control_zero(rw_out[0]),
        .charge_current_limit(rw_out[1]), .precharge_termination_current(rw_out[2]),
        .battery_voltage_limit(rw_out[3]), .charger_control_one(rw_out[4]),
        .charger_control_two(rw_out[5]), .charger_control_three(rw_out[6]),
        .control_four_reg(rw_out[7]));

    task automatic tally_and_finish();
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic ack;
        u_i2c_host_model.send_byte(b, ack);
        `CHK(ack, exp_ack)
    endtask

    task automatic wr(input int off, input logic [7:0] d [$]);
        u_i2c_host_model.start_cond();
        send(8'hd4, 1'b1);
        send(8'(off), 1'b1);
        foreach (d[i]) begin
            send(d[i], 1'b1);
            if (off + i < 8 || off + i == 12) model[off + i] = d[i];
        end
        u_i2c_host_model.stop_cond();
    endtask

    task automatic rd(input int off, input int n);
        logic [7:0] got;
        logic [7:0] exp;
        u_i2c_host_model.start_cond();
        send(8'hd4, 1'b1);
        send(8'(off), 1'b1);
        u_i2c_host_model.start_cond();
        send(8'hd5, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_i2c_host_model.recv_byte(i == n - 1, got);
            case (off + i)
                8: exp = status_zero_reg;
                9: exp = status_one_reg;
                10: exp = status_two_reg;
                11: exp = part_info_reg;
                default: exp = (off + i > 12) ? 8'hff : model[off + i];
            endcase
            `CHK(got, exp)
        end
        u_i2c_host_model.stop_cond();
    endtask

    task automatic pulse(ref logic s);
        @(posedge clock);
        #2;
        s = 1'b1;
        @(posedge clock);
        #2;
        s = 1'b0;
    endtask

    // fresh side inputs, then the limit register outputs against the model
    task automatic check_outs();
        remote_sense_fault_flag = 1'($urandom);
        thermistor_input_ok = 1'($urandom);
        thermistor_fault_raw = 3'($urandom);
        {status_zero_reg, status_one_reg, status_two_reg, part_info_reg} = $urandom;
        repeat (4) @(posedge clock);
        #2;
        `CHK(input_current_limit_code, model[0][4:0])
        `CHK(input_current_limit_ma, 12'(model[0][4:0] * 100 + 100))
        `CHK(high_impedance_enable, model[0][7])
        `CHK(thermistor_bypass, model[0][6])
        `CHK(thermistor_good, model[0][6] | thermistor_input_ok)
        `CHK(thermistor_fault_field, model[0][6] ? 3'h0 : thermistor_fault_raw)
        `CHK(remote_sense_disable, model[0][5])
        `CHK(use_remote_sense, ~model[0][5] & ~remote_sense_fault_flag)
        for (int r = 0; r < 8; r++) begin
            `CHK(rw_out[r], model[r < 7 ? r + 1 : 12])
        end
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        err_total++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h9f13a3aa));
        model = charger_regs_pkg::RW_RESET;
        repeat (5) @(posedge clock);
        #2;
        rst_n = 1'b1;
        repeat (5) @(posedge clock);
        #2;
        check_outs();
        rd(0, 14);
        for (int i = 0; i < 13; i++) begin
            q.push_back(8'($urandom));
        end
        wr(0, q);
        check_outs();
        rd(0, 13);
        u_i2c_host_model.start_cond();
        send(8'hd6, 1'b0);
        u_i2c_host_model.stop_cond();
        u_i2c_host_model.start_cond();
        send(8'hd4, 1'b1);
        send(8'h0d, 1'b0);
        u_i2c_host_model.stop_cond();
        rd(12, 3);
        for (int k = 0; k < 8; k++) begin
            d0 = {3'(k), k == 0 ? 5'h00 : k == 7 ? 5'h1f : 5'($urandom)};
            wr(0, '{d0});
            check_outs();
        end
        wr(0, '{8'he5});
        pulse(watchdog_expired);
        model[0][7] = 1'b0;
        check_outs();
        rd(0, 1);
        for (int p = 0; p < 2; p++) begin
            power_select_pin = p[0];
            repeat (6) @(posedge clock);
            pulse(detection_done);
            model[0][4:0] = p[0] ? 5'h04 : 5'h17;
            check_outs();
        end
        wr(0, '{8'h0a});
        check_outs();
        wr(0, '{8'hff});
        pulse(reg_reset);
        model = charger_regs_pkg::RW_RESET;
        check_outs();
        rd(0, 13);
        u_i2c_host_model.phase = 10;
        q = {8'($urandom), 8'($urandom), 8'($urandom)};
        wr(5, q);
        rd(4, 4);
        u_i2c_host_model.phase = 6;
        tally_and_finish();
    end
endmodule // tb_charger_register_bank

`default_nettype wire
